// ---- rtl/stm_timer.sv ----
// Purpose: Standard timer with pin remap and buffered 10-bit access
// Assumes: Byte register port, read data one cycle after the strobe
// Notes:   Time-base and high-clock rates come in as enable pulses
//
// Function
// R1: Clock pin from bit7, or bit6 when remapped
// R2: Capture pin from bit6, or bit0 when remapped
// R3: Two bits place interrupt pin on 5/2/3/7
// R4: Unused remap bits read zero, ignore writes
// R5: Timer, capture, compare, single pulse, PWM
// R6: Match interrupts, may clear counter, drive pin
// R7: Three-bit field selects counter clock source
// R8: Comparators A and P interrupt separately
// R9: External pin counts on chosen edge
// R10: Capture on rising, falling or both
// R11: Compare output sets, clears or toggles
// R12: PWM waveform drives the true output
// R13: Pin joins timer only when share selected
// R14: High bytes direct, low via one buffer
// R15: Compare low write fills buffer only
// R16: Compare high write also copies buffer
// R17: High read latches live low byte
// R18: Low read returns the buffer
// R19: Software writes low first, reads high first
// R20: Clock code map: sys/4 to ext falling
// R21: 10-bit counter, P on top three bits
// R22: Inverted pin is inverse of true pin
// R23: Rising on-bit clears counter to zero
// R24: Each match pulses its request once
// R25: Pins synchronised, each edge used once
`timescale 1ns/1ns
module stm_timer (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic [7:0] port_a_i,
  input  wire logic       hclk_en_i,
  input  wire logic       tbc_en_i,
  output logic            irq_a_o,
  output logic            irq_p_o,
  output logic            ext_irq_o,
  output logic            timer_out_true_o,
  output logic            timer_out_true_oe_o,
  output logic            timer_out_inverted_o,
  output logic            timer_out_inverted_oe_o
);

  // All state of the timer
  typedef struct packed {
    stm_pkg::stm_ctrl0_type c0;
    stm_pkg::stm_ctrl1_type c1;
    logic [7:0]             remap;
    logic [7:0]             psel;
    logic [9:0]             cnt;
    logic [9:0]             cmp_a;
    logic [7:0]             lbuf;
    logic [7:0]             rdata;
    logic                   out;
    logic                   pulse_done;
    logic                   irq_a;
    logic                   irq_p;
    logic                   ext_irq;
    logic                   oe_t;
    logic                   oe_n;
    logic                   out_n;
  } stm_state_type;

  stm_state_type st;       // Registered state
  stm_state_type next_st;  // Next state
  stm_pkg::stm_bus_type bus;  // Bundled register request

  logic ck_pin;      // Remapped clock pin
  logic cap_pin;     // Remapped capture pin
  logic ck_rise;     // Synchronised clock edges
  logic ck_fall;
  logic cap_rise;    // Synchronised capture edges
  logic cap_fall;
  logic irq_level;   // Synchronised interrupt pin
  logic tick;        // Counter enable
  logic match_a;     // Comparator A equal
  logic match_p;     // Comparator P equal
  logic cap_hit;     // Selected capture edge
  logic [1:0] ext_sel;  // Interrupt pin selector
  logic [9:0] cnt_inc;  // Counter value one tick on

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Input remapping; remap bits 5 and 4 pick clock and capture pins
  assign ck_pin  = st.remap[5] ? port_a_i[6] : port_a_i[7];  // [R1]
  assign cap_pin = st.remap[4] ? port_a_i[0] : port_a_i[6];  // [R2]
  assign ext_sel = st.remap[1:0];

  // Clock pin synchroniser
  stm_sync u_ck_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (ck_pin),
    .level_o   (),
    .rise_o    (ck_rise),
    .fall_o    (ck_fall)
  );

  // Capture pin synchroniser
  stm_sync u_cap_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (cap_pin),
    .level_o   (),
    .rise_o    (cap_rise),
    .fall_o    (cap_fall)
  );

  // Interrupt pin placement, then synchronised
  logic ext_pin;
  always_comb begin
    case (ext_sel)  // [R3]
      stm_pkg::STM_IO_0: ext_pin = port_a_i[5];
      stm_pkg::STM_IO_1: ext_pin = port_a_i[2];
      stm_pkg::STM_IO_2: ext_pin = port_a_i[3];
      stm_pkg::STM_IO_3: ext_pin = port_a_i[7];
      default:           ext_pin = port_a_i[5];
    endcase
  end

  stm_sync u_irq_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (ext_pin),
    .level_o   (irq_level),
    .rise_o    (),
    .fall_o    ()
  );

  // Counter clock source; paused or off timer ignores ticks downstream
  stm_prescale u_pre (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .sel_i      (st.c0.ck_sel),
    .hclk_en_i  (hclk_en_i),
    .tbc_en_i   (tbc_en_i),
    .ext_rise_i (ck_rise & st.psel[0]),  // Pin counts only when shared in [R13]
    .ext_fall_i (ck_fall & st.psel[0]),
    .tick_o     (tick)
  );

  // Comparators: P on top three bits, A on all ten [R21]
  // They judge the value the next tick would load, so a clearing match replaces it:
  // the period is the compare value in ticks, and period zero wraps at full count
  assign cnt_inc = st.cnt + 10'h001;
  assign match_a = cnt_inc == st.cmp_a;
  assign match_p = (cnt_inc[9:7] == st.c0.period) & (cnt_inc[6:0] == 7'h00);

  // Capture edge choice [R10]
  always_comb begin
    case (st.c1.io_sel)
      stm_pkg::STM_IO_0: cap_hit = cap_rise;
      stm_pkg::STM_IO_1: cap_hit = cap_fall;
      stm_pkg::STM_IO_2: cap_hit = cap_rise | cap_fall;
      default:           cap_hit = 1'b0;
    endcase
  end

  // Main next-state process
  always_comb begin
    logic run;
    logic hit_a;
    logic hit_p;
    run     = 1'b0;
    hit_a   = 1'b0;
    hit_p   = 1'b0;
    next_st = st;
    run     = tick & st.c0.on & ~st.c0.pause;
    // A and P requests are one-cycle pulses [R24]
    next_st.irq_a   = 1'b0;
    next_st.irq_p   = 1'b0;
    next_st.ext_irq = irq_level;

    // Counting and match handling [R5] [R6]
    if (run) begin
      hit_a = match_a & (st.c1.mode != stm_pkg::STM_MODE_CAP);
      hit_p = match_p;
      next_st.irq_a = hit_a;  // [R8]
      next_st.irq_p = hit_p;  // [R8]
      if ((st.c1.cclr & hit_a) | (~st.c1.cclr & hit_p)) begin
        next_st.cnt = stm_pkg::STM_CNT_ZERO;  // Match clears counter [R6]
      end else begin
        next_st.cnt = cnt_inc;
      end
    end

    // Capture mode latches the counter into compare A
    if (st.c1.mode == stm_pkg::STM_MODE_CAP && st.c0.on && cap_hit && st.psel[1]) begin
      next_st.cmp_a = st.cnt;  // [R10] [R13]
      next_st.irq_a = 1'b1;
    end

    // Output pin behaviour per mode
    case (st.c1.mode)
      stm_pkg::STM_MODE_CMP: begin
        if (hit_a) begin
          case (st.c1.io_sel)  // [R11]
            stm_pkg::STM_IO_1: next_st.out = 1'b0;
            stm_pkg::STM_IO_2: next_st.out = 1'b1;
            stm_pkg::STM_IO_3: next_st.out = ~st.out;
            default:           next_st.out = st.out;
          endcase
        end
      end
      stm_pkg::STM_MODE_PWM: begin
        case (st.c1.io_sel)
          stm_pkg::STM_IO_0: next_st.out = ~st.c1.init_lvl;
          stm_pkg::STM_IO_1: next_st.out = st.c1.init_lvl;
          stm_pkg::STM_IO_2: begin
            // Active until A match, inactive to period end [R12]
            if (hit_p) begin
              next_st.out = st.c1.init_lvl;
            end else if (hit_a) begin
              next_st.out = ~st.c1.init_lvl;
            end
          end
          default: begin
            // Single pulse ends at A match
            if (hit_a && !st.pulse_done) begin
              next_st.out        = ~st.c1.init_lvl;
              next_st.pulse_done = 1'b1;
            end
          end
        endcase
      end
      default: next_st.out = st.out;  // Capture and timer hold the pin
    endcase

    // Register port writes
    if (bus.wr) begin
      case (bus.addr)
        stm_pkg::STM_ADDR_CTRL0: begin
          next_st.c0 = stm_pkg::stm_ctrl0_type'(bus.wdata);
          if (bus.wdata[3] && !st.c0.on) begin
            next_st.cnt        = stm_pkg::STM_CNT_ZERO;  // Off-to-on clears [R23]
            next_st.out        = st.c1.init_lvl;
            next_st.pulse_done = 1'b0;
          end
        end
        stm_pkg::STM_ADDR_CTRL1: next_st.c1 = stm_pkg::stm_ctrl1_type'(bus.wdata);
        stm_pkg::STM_ADDR_CMPL:  next_st.lbuf = bus.wdata;  // Buffer only [R14] [R15]
        stm_pkg::STM_ADDR_CMPH:  next_st.cmp_a = {bus.wdata[1:0], st.lbuf};  // [R16]
        stm_pkg::STM_ADDR_REMAP: next_st.remap = bus.wdata & stm_pkg::STM_REMAP_MASK;  // [R4]
        stm_pkg::STM_ADDR_PSEL:  next_st.psel = bus.wdata & stm_pkg::STM_PSEL_MASK;
        default:                 next_st.c0 = next_st.c0;  // Counter is read only [R23]
      endcase
    end

    // Register port reads, data valid next cycle
    next_st.rdata = stm_pkg::STM_RST_BYTE;
    if (bus.rd) begin
      case (bus.addr)
        stm_pkg::STM_ADDR_CTRL0: next_st.rdata = st.c0;
        stm_pkg::STM_ADDR_CTRL1: next_st.rdata = st.c1;
        stm_pkg::STM_ADDR_CNTL:  next_st.rdata = st.lbuf;  // [R18]
        stm_pkg::STM_ADDR_CNTH: begin
          next_st.rdata = {6'h00, st.cnt[9:8]};
          next_st.lbuf  = st.cnt[7:0];  // [R17]
        end
        stm_pkg::STM_ADDR_CMPL:  next_st.rdata = st.lbuf;  // [R18]
        stm_pkg::STM_ADDR_CMPH: begin
          next_st.rdata = {6'h00, st.cmp_a[9:8]};
          next_st.lbuf  = st.cmp_a[7:0];  // [R17]
        end
        stm_pkg::STM_ADDR_REMAP: next_st.rdata = st.remap;  // Reserved bits zero [R4]
        stm_pkg::STM_ADDR_PSEL:  next_st.rdata = st.psel;
        default:                 next_st.rdata = stm_pkg::STM_RST_BYTE;
      endcase
    end

    // Pins driven only when share selects the timer [R13]
    next_st.oe_t  = st.psel[2] && st.c0.on && (st.c1.mode != stm_pkg::STM_MODE_TMR);
    next_st.oe_n  = st.psel[3] && st.c0.on && (st.c1.mode != stm_pkg::STM_MODE_TMR);
    next_st.out_n = ~next_st.out;  // [R22]
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.out_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Registered outputs
  assign rdata_o                 = st.rdata;
  assign irq_a_o                 = st.irq_a;
  assign irq_p_o                 = st.irq_p;
  assign ext_irq_o               = st.ext_irq;
  assign timer_out_true_o        = st.out;
  assign timer_out_true_oe_o     = st.oe_t;
  assign timer_out_inverted_o    = st.out_n;
  assign timer_out_inverted_oe_o = st.oe_n;

  // Inverted pin always opposes the true pin
  pin_inverse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timer_out_inverted_o == ~timer_out_true_o) else $error("inverted pin not inverse"); // [R22]

  // Request lasts one cycle
  irq_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_a_o |=> !irq_a_o || $past(cap_hit)) else $error("compare A request too long"); // [R24]

  // Period request one cycle
  period_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_p_o |=> !irq_p_o) else $error("period request too long"); // [R24]

  // Remap reads keep reserved bits zero
  remap_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == stm_pkg::STM_ADDR_REMAP) |=> (rdata_o & 8'hCC) == 8'h00)
    else $error("reserved remap bits set"); // [R4]

  // Compare low write leaves compare value
  cmp_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == stm_pkg::STM_ADDR_CMPL && st.c1.mode != stm_pkg::STM_MODE_CAP)
    |=> st.cmp_a == $past(st.cmp_a)) else $error("low write changed compare"); // [R15]

  // High write merges buffer
  cmp_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == stm_pkg::STM_ADDR_CMPH) |=> st.cmp_a[7:0] == $past(st.lbuf))
    else $error("high write lost buffer"); // [R16]

  // High read then low read returns latched low
  cnt_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == stm_pkg::STM_ADDR_CNTH) ##1 (rd_i && addr_i == stm_pkg::STM_ADDR_CNTL && !wr_i)
    |=> rdata_o == $past(st.cnt[7:0], 2)) else $error("low byte not latched"); // [R17]

  // Turning on clears the counter
  on_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == stm_pkg::STM_ADDR_CTRL0 && wdata_i[3] && !st.c0.on)
    |=> st.cnt == stm_pkg::STM_CNT_ZERO) else $error("counter not cleared"); // [R23]

  // Clearing match on A restarts the count
  match_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R6]
    (tick && st.c0.on && !st.c0.pause && st.c1.cclr && match_a && st.c1.mode != stm_pkg::STM_MODE_CAP)
    |=> st.cnt == stm_pkg::STM_CNT_ZERO) else $error("match did not clear counter");

  // Stopped counter keeps its value
  off_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R23]
    (!st.c0.on && !(wr_i && addr_i == stm_pkg::STM_ADDR_CTRL0)) |=> $stable(st.cnt))
    else $error("stopped counter moved");

endmodule

// ---- rtl/stm_pkg.sv ----
// Purpose: Shared constants and carrier types for the standard timer block
// Assumes: Byte-wide register port, one system clock at 25 MHz
// Notes:   Register offsets are byte indices on the plain register port
package stm_pkg;

  // Register offsets on the plain port
  localparam logic [2:0] STM_ADDR_CTRL0 = 3'h0;  // Control 0
  localparam logic [2:0] STM_ADDR_CTRL1 = 3'h1;  // Control 1
  localparam logic [2:0] STM_ADDR_CNTL  = 3'h2;  // Counter low (buffered)
  localparam logic [2:0] STM_ADDR_CNTH  = 3'h3;  // Counter high
  localparam logic [2:0] STM_ADDR_CMPL  = 3'h4;  // Compare A low (buffered)
  localparam logic [2:0] STM_ADDR_CMPH  = 3'h5;  // Compare A high
  localparam logic [2:0] STM_ADDR_REMAP = 3'h6;  // Input pin remap
  localparam logic [2:0] STM_ADDR_PSEL  = 3'h7;  // Pin share selects

  // Field masks and reset values
  localparam logic [7:0] STM_REMAP_MASK = 8'h33;  // Implemented remap bits
  localparam logic [7:0] STM_PSEL_MASK  = 8'h0F;  // Implemented share bits
  localparam logic [7:0] STM_RST_BYTE   = 8'h00;  // Reset of every register

  // Counter clock selections
  localparam logic [2:0] STM_CK_SYS4  = 3'h0;
  localparam logic [2:0] STM_CK_SYS   = 3'h1;
  localparam logic [2:0] STM_CK_H16   = 3'h2;
  localparam logic [2:0] STM_CK_H64   = 3'h3;
  localparam logic [2:0] STM_CK_TBC0  = 3'h4;
  localparam logic [2:0] STM_CK_TBC1  = 3'h5;
  localparam logic [2:0] STM_CK_EXTR  = 3'h6;
  localparam logic [2:0] STM_CK_EXTF  = 3'h7;

  // Operating modes
  localparam logic [1:0] STM_MODE_CMP = 2'h0;
  localparam logic [1:0] STM_MODE_CAP = 2'h1;
  localparam logic [1:0] STM_MODE_PWM = 2'h2;
  localparam logic [1:0] STM_MODE_TMR = 2'h3;

  // Function select codes
  localparam logic [1:0] STM_IO_0 = 2'h0;
  localparam logic [1:0] STM_IO_1 = 2'h1;
  localparam logic [1:0] STM_IO_2 = 2'h2;
  localparam logic [1:0] STM_IO_3 = 2'h3;

  // Prescaler divide points
  localparam logic [5:0] STM_DIV4_MASK  = 6'h03;
  localparam logic [5:0] STM_DIV16_MASK = 6'h0F;
  localparam logic [5:0] STM_DIV64_MASK = 6'h3F;
  localparam logic [9:0] STM_CNT_ZERO   = 10'h000;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stm_bus_type;

  // Control 0 layout
  typedef struct packed {
    logic       pause;
    logic [2:0] ck_sel;
    logic       on;
    logic [2:0] period;
  } stm_ctrl0_type;

  // Control 1 layout
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] io_sel;
    logic       init_lvl;
    logic       pol;
    logic       dpx;
    logic       cclr;
  } stm_ctrl1_type;

endpackage

// ---- rtl/stm_sync.sv ----
// Purpose: Three-stage pin synchroniser with edge pulses
// Assumes: Input is asynchronous to clk_i
// Notes:   Edges are judged on stages two and three only
`timescale 1ns/1ns
module stm_sync (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  // All state of the synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } stm_sync_type;

  stm_sync_type st;       // Registered state
  stm_sync_type next_st;  // Next state

  // Shift chain; stage one feeds stage two only
  always_comb begin
    next_st      = st;
    next_st.s1   = pin_i;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = st.s2 & ~st.s3;  // One pulse per edge [R25]
    next_st.fall = ~st.s2 & st.s3;  // [R25]
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.s3;
  assign rise_o  = st.rise;
  assign fall_o  = st.fall;

endmodule

// ---- rtl/stm_prescale.sv ----
// Purpose: Counter clock enable generator
// Assumes: Time-base and high-clock ticks arrive as clk_i enables
// Notes:   Every slower rate is a one-cycle enable pulse
`timescale 1ns/1ns
module stm_prescale (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       hclk_en_i,
  input  wire logic       tbc_en_i,
  input  wire logic       ext_rise_i,
  input  wire logic       ext_fall_i,
  output logic            tick_o
);

  // All state of the prescaler
  typedef struct packed {
    logic [5:0] sys_div;
    logic [5:0] h_div;
    logic       tick;
  } stm_pre_type;

  stm_pre_type st;       // Registered state
  stm_pre_type next_st;  // Next state

  // Divider chains and source mux
  always_comb begin
    next_st         = st;
    next_st.sys_div = st.sys_div + 6'h01;
    if (hclk_en_i) begin
      next_st.h_div = st.h_div + 6'h01;
    end
    case (sel_i)  // [R7] [R20]
      stm_pkg::STM_CK_SYS4: next_st.tick = (st.sys_div & stm_pkg::STM_DIV4_MASK) == stm_pkg::STM_DIV4_MASK;
      stm_pkg::STM_CK_SYS:  next_st.tick = 1'b1;
      stm_pkg::STM_CK_H16:  next_st.tick = hclk_en_i &
                                ((st.h_div & stm_pkg::STM_DIV16_MASK) == stm_pkg::STM_DIV16_MASK);
      stm_pkg::STM_CK_H64:  next_st.tick = hclk_en_i & (st.h_div == stm_pkg::STM_DIV64_MASK);
      stm_pkg::STM_CK_TBC0,
      stm_pkg::STM_CK_TBC1: next_st.tick = tbc_en_i;
      stm_pkg::STM_CK_EXTR: next_st.tick = ext_rise_i;  // Event counting [R9]
      stm_pkg::STM_CK_EXTF: next_st.tick = ext_fall_i;  // [R9]
      default:              next_st.tick = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule

// ---- dv/stm_pins_model.sv ----
// Purpose: Far-side model of the port A pins and slow rate ticks
// Assumes: Pins change only just after a rising clk_i edge
// Notes:   Pins are driven inputs, so they hold a level between pulses
`timescale 1ns/1ns
module stm_pins_model (
  input  wire logic  clk_i,
  output logic [7:0] port_a_o,
  output logic       hclk_en_o,
  output logic       tbc_en_o
);
  logic [3:0] div_q;  // Free divider for the slow ticks

  initial begin
    port_a_o = 8'h00;
    div_q    = 4'h0;
  end

  // Divider runs always, so slow rates are exercised too
  always @(posedge clk_i) begin
    div_q <= div_q + 4'h1;
  end

  assign hclk_en_o = (div_q[1:0] == 2'h3);  // One in four
  assign tbc_en_o  = (div_q == 4'hF);       // One in sixteen

  // Level change on one pin
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_i);
    port_a_o[idx] <= v;
  endtask

  // Whole pulse; each phase outlasts the synchroniser delay
  task automatic pulse(input int idx);
    set_pin(idx, 1'b1);
    repeat (4) @(posedge clk_i);
    port_a_o[idx] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the standard timer block
// Assumes: Plain register port, pins driven by the pin model
// Notes:   Counts use the external pin clock so they are exact
`timescale 1ns/1ns
module tb_top;
  logic       clk_i;
  logic       sys_rst_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [7:0] port_a_i;
  logic       hclk_en_i;
  logic       tbc_en_i;
  logic       irq_a_o;
  logic       irq_p_o;
  logic       ext_irq_o;
  logic       out_t;
  logic       out_t_oe;
  logic       out_n;
  logic       out_n_oe;
  logic [7:0] rd_v;     // Last read data
  int         error_cnt;
  int         n_compared;
  int         cyc;      // Cycle count for the hang guard
  int         na;       // Compare A requests seen
  int         np;       // Compare P requests seen
  int         tp_prev;
  int         tp_last;
  int         ta_prev;
  int         ta_last;
  int         ck_code [5] = '{0, 2, 3, 4, 5};       // Slower clock codes
  int         ck_ivl  [5] = '{4, 64, 256, 16, 16};  // Cycles per tick at the model's rates
  int         sel_pin [4] = '{5, 2, 3, 7};  // Interrupt pin per code
  int         cap_exp [4] = '{1, 1, 2, 0};  // Captures per single pulse

  stm_timer dut_u (
    .clk_i                   (clk_i),
    .sys_rst_i               (sys_rst_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .port_a_i                (port_a_i),
    .hclk_en_i               (hclk_en_i),
    .tbc_en_i                (tbc_en_i),
    .irq_a_o                 (irq_a_o),
    .irq_p_o                 (irq_p_o),
    .ext_irq_o               (ext_irq_o),
    .timer_out_true_o        (out_t),
    .timer_out_true_oe_o     (out_t_oe),
    .timer_out_inverted_o    (out_n),
    .timer_out_inverted_oe_o (out_n_oe)
  );

  stm_pins_model pins_u (
    .clk_i     (clk_i),
    .port_a_o  (port_a_i),
    .hclk_en_o (hclk_en_i),
    .tbc_en_o  (tbc_en_i)
  );

  always #20 clk_i = ~clk_i;

  // Request counters and hang guard; sampled before the edge updates land
  always @(posedge clk_i) begin
    cyc++;
    if (irq_a_o === 1'b1) begin
      na++;
      ta_prev = ta_last;
      ta_last = cyc;
    end
    if (irq_p_o === 1'b1) begin
      np++;
      tp_prev = tp_last;
      tp_last = cyc;
    end
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // One-cycle write strobe; a gap cycle keeps strobes single-assigned
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    chk(nm, exp, rd_v);
  endtask

  // High byte then low byte back to back, so the low byte comes from the buffer
  task automatic cnt_chk(input logic [9:0] exp);
    @(posedge clk_i);
    addr_i <= stm_pkg::STM_ADDR_CNTH;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    addr_i <= stm_pkg::STM_ADDR_CNTL;
    #1 rd_v = rdata_o;
    chk("cnt_hi", {6'h00, exp[9:8]}, rd_v);
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
    chk("cnt_lo", exp[7:0], rd_v);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask

  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_i     = 1'b0;
    sys_rst_i = 1'b1;
    addr_i    = 3'h0;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Every register clears on reset
    for (int a = 0; a < 8; a++) rchk("reset", a[2:0], stm_pkg::STM_RST_BYTE);
    // Unused remap bits stay zero
    wr(stm_pkg::STM_ADDR_REMAP, 8'hFF);
    rchk("remap", stm_pkg::STM_ADDR_REMAP, 8'h33);
    // Interrupt pin placement, every code
    for (int k = 0; k < 4; k++) begin
      wr(stm_pkg::STM_ADDR_REMAP, {6'h00, k[1:0]});
      pins_u.set_pin(sel_pin[k], 1'b1);
      settle();
      chk("ext_irq_hi", 8'h01, {7'h00, ext_irq_o});
      pins_u.set_pin(sel_pin[k], 1'b0);
      settle();
      chk("ext_irq_lo", 8'h00, {7'h00, ext_irq_o});
    end
    // Buffered compare access; a stray low write must not reach the value
    wr(stm_pkg::STM_ADDR_CMPL, 8'h5A);
    wr(stm_pkg::STM_ADDR_CMPH, 8'h02);
    wr(stm_pkg::STM_ADDR_CMPL, 8'h77);
    rchk("cmp_hi", stm_pkg::STM_ADDR_CMPH, 8'h02);
    rchk("cmp_lo", stm_pkg::STM_ADDR_CMPL, 8'h5A);
    // Counter cannot be written
    wr(stm_pkg::STM_ADDR_CNTL, 8'hFF);
    wr(stm_pkg::STM_ADDR_CNTH, 8'h03);
    cnt_chk(10'h000);
    // Event counting on the external pin, default then remapped
    wr(stm_pkg::STM_ADDR_PSEL, 8'h0F);
    wr(stm_pkg::STM_ADDR_REMAP, 8'h00);
    wr(stm_pkg::STM_ADDR_CTRL1, 8'h01);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h68);
    repeat (5) pins_u.pulse(7);
    settle();
    cnt_chk(10'h005);
    wr(stm_pkg::STM_ADDR_REMAP, 8'h20);
    repeat (3) pins_u.pulse(7);
    repeat (2) pins_u.pulse(6);
    settle();
    cnt_chk(10'h007);
    // Share bit off: the pin no longer reaches the timer
    wr(stm_pkg::STM_ADDR_PSEL, 8'h0E);
    repeat (2) pins_u.pulse(6);
    settle();
    cnt_chk(10'h007);
    // Falling edge selection, then off keeps and on clears
    wr(stm_pkg::STM_ADDR_PSEL, 8'h0F);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h78);
    pins_u.pulse(6);
    settle();
    cnt_chk(10'h008);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h70);
    cnt_chk(10'h008);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h78);
    cnt_chk(10'h000);
    // Compare A match toggles the outputs and requests once
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h60);
    wr(stm_pkg::STM_ADDR_REMAP, 8'h00);
    wr(stm_pkg::STM_ADDR_CMPL, 8'h03);
    wr(stm_pkg::STM_ADDR_CMPH, 8'h00);
    wr(stm_pkg::STM_ADDR_CTRL1, 8'h31);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h68);
    na = 0;
    repeat (3) pins_u.pulse(7);
    settle();
    chk("irq_a", 8'h01, na[7:0]);
    chk("out_true", 8'h01, {7'h00, out_t});
    chk("out_inv", 8'h00, {7'h00, out_n});
    chk("out_oe", 8'h03, {6'h00, out_t_oe, out_n_oe});
    // Capture edge choices, one pulse each
    for (int m = 0; m < 4; m++) begin
      wr(stm_pkg::STM_ADDR_CTRL0, 8'h60);
      wr(stm_pkg::STM_ADDR_CTRL1, {2'h1, m[1:0], 4'h0});
      wr(stm_pkg::STM_ADDR_CTRL0, 8'h68);
      na = 0;
      pins_u.pulse(6);
      settle();
      chk("capture", cap_exp[m][7:0], na[7:0]);
    end
    // Period match every 128 system clocks, clearing the counter
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h00);
    wr(stm_pkg::STM_ADDR_CTRL1, 8'h00);
    wr(stm_pkg::STM_ADDR_CTRL0, 8'h19);
    np = 0;
    for (int w = 0; w < 600 && np < 2; w++) @(posedge clk_i);
    chk("period", 8'h80, 8'(tp_last - tp_prev));
    // Slower clock sources: compare A of one clears on every tick
    wr(stm_pkg::STM_ADDR_CMPL, 8'h01);
    wr(stm_pkg::STM_ADDR_CMPH, 8'h00);
    wr(stm_pkg::STM_ADDR_CTRL1, 8'h01);
    for (int s = 0; s < 5; s++) begin
      wr(stm_pkg::STM_ADDR_CTRL0, 8'h00);
      wr(stm_pkg::STM_ADDR_CTRL0, {1'b0, ck_code[s][2:0], 4'h8});
      na = 0;
      for (int w = 0; w < 900 && na < 3; w++) @(posedge clk_i);
      chk("ck_ivl_hi", 8'(ck_ivl[s] >> 8), 8'((ta_last - ta_prev) >> 8));
      chk("ck_ivl_lo", 8'(ck_ivl[s]), 8'(ta_last - ta_prev));
    end
    // Mid-run reset releases the output pins and restores defaults
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk("oe_rst", 8'h00, {6'h00, out_t_oe, out_n_oe});
    rchk("rst_ctrl0", stm_pkg::STM_ADDR_CTRL0, stm_pkg::STM_RST_BYTE);
    close_out();
  end
endmodule
